// [bsad_defines.vh]
// Purpose: shared constants of the bit-slice arithmetic datapath
// Assumes: included by bare name from every design file
// Notes:   offsets are byte addresses on the register bus
`ifndef BSAD_DEFINES_VH
`define BSAD_DEFINES_VH

// ****************************************************************
// register map
// ****************************************************************
`define BSAD_OFS_DLO      8'h00
`define BSAD_OFS_DHI      8'h04
`define BSAD_OFS_CTRL     8'h08
`define BSAD_OFS_STATUS   8'h0C
`define BSAD_OFS_RES_LO   8'h10
`define BSAD_OFS_RES_HI   8'h14

// ctrl fields: shift fill bits at the word ends
`define BSAD_CTRL_RAM_LO  0
`define BSAD_CTRL_RAM_HI  1
`define BSAD_CTRL_Q_LO    2
`define BSAD_CTRL_Q_HI    3
`define BSAD_CTRL_RST     4'h0

// status fields
`define BSAD_ST_ZERO      0
`define BSAD_ST_SIGN      1
`define BSAD_ST_OVR       2
`define BSAD_ST_COUT      3

`define BSAD_DATA_RST     32'h0000_0000
`define BSAD_RESP_OKAY    2'h0
`define BSAD_RESP_SLVERR  2'h2

// ****************************************************************
// source select codes (left, right)
// ****************************************************************
`define BSAD_SRC_AQ       3'h0
`define BSAD_SRC_AB       3'h1
`define BSAD_SRC_ZQ       3'h2
`define BSAD_SRC_ZB       3'h3
`define BSAD_SRC_ZA       3'h4
`define BSAD_SRC_DA       3'h5
`define BSAD_SRC_DQ       3'h6
`define BSAD_SRC_DZ       3'h7

// ****************************************************************
// function select codes
// ****************************************************************
`define BSAD_FN_ADD       3'h0
`define BSAD_FN_SMINR     3'h1
`define BSAD_FN_RMINS     3'h2
`define BSAD_FN_OR        3'h3
`define BSAD_FN_AND       3'h4
`define BSAD_FN_NOTRS     3'h5
`define BSAD_FN_XOR       3'h6
`define BSAD_FN_XNOR      3'h7

// ****************************************************************
// destination select codes
// ****************************************************************
`define BSAD_DST_QREG     3'h0
`define BSAD_DST_NOP      3'h1
`define BSAD_DST_RAMA     3'h2
`define BSAD_DST_RAMF     3'h3
`define BSAD_DST_RAMQD    3'h4
`define BSAD_DST_RAMD     3'h5
`define BSAD_DST_RAMQU    3'h6
`define BSAD_DST_RAMU     3'h7

`endif

// [bsad_slice.v]
// Purpose: one 4-bit slice: scratch ram, aux shift register, operand muxes, alu
// Assumes: carry into the slice comes from the look-ahead tree outside
// Notes:   ram write and aux load both commit at the rising edge
`include "bsad_defines.vh"

module bsad_slice #(
    parameter W = 4,                       // slice width
    parameter N = 16                       // scratch words
) (
    input  wire           mclk,
    input  wire           rst_b,
    input  wire           uins_valid,     // microinstruction present this cycle
    input  wire [2:0]     source_select_field,
    input  wire [2:0]     function_select_field,
    input  wire [2:0]     destination_select_field,
    input  wire [3:0]     first_read_address,
    input  wire [3:0]     second_read_write_address,
    input  wire [W-1:0]   direct_in,      // direct data operand bits
    input  wire           carry_in,       // carry into this slice
    input  wire           ram_dn_in,      // bit entering msb on shift down
    input  wire           ram_up_in,      // bit entering lsb on shift up
    input  wire           q_dn_in,
    input  wire           q_up_in,
    output reg  [W-1:0]   alu_f,          // alu result bits
    output wire [W-1:0]   a_port,         // first read port
    output wire [W-1:0]   q_bits,         // aux shift register contents
    output reg            grp_gen,        // slice carry generate
    output reg            grp_prop,       // slice carry propagate
    output reg            msb_carry       // carry into slice msb
);

    // ****************************************************************
    // storage
    // ****************************************************************
    reg [W-1:0] ram [0:N-1];              // scratch words, no reset
    reg [W-1:0] q_ff;                     // aux shift register
    reg [W-1:0] alu_left_operand;
    reg [W-1:0] alu_right_operand;
    reg [W-1:0] opa;                      // possibly inverted left
    reg [W-1:0] opb;                      // possibly inverted right
    reg [W-1:0] gen;
    reg [W-1:0] prop;
    reg [W:0]   cy;                       // ripple of look-ahead terms
    reg [W-1:0] ram_in;                   // write data after shifter
    reg         arith;
    integer     i;

    // both ports read at once; equal codes give the same word
    assign a_port = ram[first_read_address];
    wire [W-1:0] b_port = ram[second_read_write_address];
    assign q_bits = q_ff;

    // operand selection, inhibit gives a zero source
    always @* begin
        case (source_select_field)
            `BSAD_SRC_AQ: begin alu_left_operand = a_port;    alu_right_operand = q_ff;    end
            `BSAD_SRC_AB: begin alu_left_operand = a_port;    alu_right_operand = b_port;  end
            `BSAD_SRC_ZQ: begin alu_left_operand = {W{1'b0}}; alu_right_operand = q_ff;    end
            `BSAD_SRC_ZB: begin alu_left_operand = {W{1'b0}}; alu_right_operand = b_port;  end
            `BSAD_SRC_ZA: begin alu_left_operand = {W{1'b0}}; alu_right_operand = a_port;  end
            // external data enters here and in the DQ and DZ codes below
            `BSAD_SRC_DA: begin alu_left_operand = direct_in; alu_right_operand = a_port;  end
            `BSAD_SRC_DQ: begin alu_left_operand = direct_in; alu_right_operand = q_ff;    end
            default:      begin alu_left_operand = direct_in; alu_right_operand = {W{1'b0}}; end
        endcase
    end

    // ****************************************************************
    // alu
    // ****************************************************************
    // subtraction adds inverted subtrahend plus carry
    always @* begin
        arith = (function_select_field == `BSAD_FN_ADD) ||
                (function_select_field == `BSAD_FN_SMINR) ||
                (function_select_field == `BSAD_FN_RMINS);
        opa = (function_select_field == `BSAD_FN_SMINR) ? ~alu_left_operand : alu_left_operand;
        opb = (function_select_field == `BSAD_FN_RMINS) ? ~alu_right_operand : alu_right_operand;
        gen  = opa & opb;
        prop = opa ^ opb;
        cy[0] = carry_in;
        for (i = 0; i < W; i = i + 1) begin
            cy[i+1] = gen[i] | (prop[i] & cy[i]);
        end
        // slice terms for the tree; logic ops neither make nor pass carry
        grp_gen  = 1'b0;
        grp_prop = arith;
        for (i = 0; i < W; i = i + 1) begin
            grp_gen  = gen[i] | (prop[i] & grp_gen);
            grp_prop = grp_prop & prop[i];
        end
        if (!arith) begin
            grp_gen = 1'b0;
        end
        msb_carry = arith ? cy[W-1] : 1'b0;
        // eight functions
        case (function_select_field)
            `BSAD_FN_OR:    alu_f = alu_left_operand | alu_right_operand;
            `BSAD_FN_AND:   alu_f = alu_left_operand & alu_right_operand;
            `BSAD_FN_NOTRS: alu_f = ~alu_left_operand & alu_right_operand;
            `BSAD_FN_XOR:   alu_f = alu_left_operand ^ alu_right_operand;
            `BSAD_FN_XNOR:  alu_f = ~(alu_left_operand ^ alu_right_operand);
            default:        alu_f = prop ^ cy[W-1:0];
        endcase
    end

    // three-way shifter in front of the ram
    always @* begin
        case (destination_select_field)
            `BSAD_DST_RAMQD, `BSAD_DST_RAMD: ram_in = {ram_dn_in, alu_f[W-1:1]};
            `BSAD_DST_RAMQU, `BSAD_DST_RAMU: ram_in = {alu_f[W-2:0], ram_up_in};
            default:                         ram_in = alu_f;
        endcase
    end

    // ****************************************************************
    // write-back
    // ****************************************************************
    // write always goes to the second address
    // edge write stands in for the low-phase write; reads stay transparent
    always @(posedge mclk) begin
        if (uins_valid && (destination_select_field >= `BSAD_DST_RAMA)) begin
            ram[second_read_write_address] <= ram_in;
        end
    end

    // aux register loads on the rising edge
    always @(posedge mclk) begin
        if (!rst_b) begin
            q_ff <= {W{1'b0}};
        end else if (uins_valid) begin
            case (destination_select_field)
                `BSAD_DST_QREG:  q_ff <= alu_f;
                `BSAD_DST_RAMQD: q_ff <= {q_dn_in, q_ff[W-1:1]};
                `BSAD_DST_RAMQU: q_ff <= {q_ff[W-2:0], q_up_in};
                default:         q_ff <= q_ff;
            endcase
        end
    end

endmodule // bsad_slice

// [bsad_datapath.v]
// Purpose: 64-bit datapath of sixteen cascaded slices with an AXI4-Lite port
// Assumes: control store drives one microinstruction per clock
// Notes:   direct data and shift fill bits come from registers
`include "bsad_defines.vh"

// Function
// - sixteen 64-bit words, first address reads
// - second address reads, both ports together
// - same address gives identical data both
// - writes always go to second address
// - write data unshifted, shifted up, down
// - left two-input, right three-input operand mux
// - inhibit forces zero operand
// - source field picks operand pairs
// - external data enters via direct input
// - auxiliary shift register beside storage
// - function field picks eight alu operations
// - sixteen 4-bit slices make 64 bits
// - destination field steers writes and output
// - aux on rising edge, reads transparent
// - zero, sign and overflow flags
// - three-level look-ahead, carry out flag
module bsad_datapath #(
    parameter NSL    = 16,                 // slice count
    parameter SW     = 4,                  // slice width
    parameter ADDR_W = 8                   // bus address width
) (
    input  wire                 mclk,
    input  wire                 rst_b,
    input  wire                 uins_valid,
    input  wire [2:0]           source_select_field,
    input  wire [2:0]           function_select_field,
    input  wire [2:0]           destination_select_field,
    input  wire [3:0]           first_read_address,
    input  wire [3:0]           second_read_write_address,
    input  wire                 carry_input,
    output reg  [NSL*SW-1:0]    y_data_ff,        // registered data output
    output reg                  y_valid_ff,
    output reg                  zero_flag_ff,
    output reg                  result_sign_ff,
    output reg                  overflow_flag_ff,
    output reg                  carry_output_ff,
    input  wire [ADDR_W-1:0]    s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output reg                  s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output reg                  s_axi_wready,
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    input  wire [ADDR_W-1:0]    s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output reg                  s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready
);

    localparam DW = NSL * SW;              // full word width
    localparam NG = NSL / 4;               // groups of four slices
    // ****************************************************************
    // software registers
    // ****************************************************************
    reg  [31:0]       dlo_ff;              // direct data low half
    reg  [31:0]       dhi_ff;              // direct data high half
    reg  [3:0]        ctrl_ff;             // shift fill bits
    reg  [ADDR_W-1:0] awaddr_ff;           // held write address
    reg  [31:0]       wdata_ff;            // held write data
    reg  [3:0]        wstrb_ff;
    reg               aw_held_ff;
    reg               w_held_ff;

    // ****************************************************************
    // slice array and carry tree
    // ****************************************************************
    wire [DW-1:0]  f_bus;                  // alu result
    wire [DW-1:0]  a_bus;                  // first read port
    wire [DW-1:0]  q_bus;                  // aux register
    wire [NSL-1:0] sg;                     // slice generate
    wire [NSL-1:0] sp;                     // slice propagate
    wire [NSL-1:0] smc;                    // carry into slice msb
    wire [NSL-1:0] sc;                     // carry into each slice
    wire [NG-1:0]  gg;                     // group generate
    wire [NG-1:0]  gp;                     // group propagate
    wire [NG-1:0]  gc;                     // carry into each group
    wire [DW-1:0]  d_word = {dhi_ff, dlo_ff};
    // shift chains padded with the fill bits, so no slice indexes past a word end
    wire [DW:0]    f_dn = {ctrl_ff[`BSAD_CTRL_RAM_HI], f_bus};
    wire [DW:0]    f_up = {f_bus, ctrl_ff[`BSAD_CTRL_RAM_LO]};
    wire [DW:0]    q_dn = {ctrl_ff[`BSAD_CTRL_Q_HI], q_bus};
    wire [DW:0]    q_up = {q_bus, ctrl_ff[`BSAD_CTRL_Q_LO]};

    // group generate over four terms
    function grp_g;
        input [3:0] g;
        input [3:0] p;
        begin
            grp_g = g[3] | (p[3] & g[2]) | (p[3] & p[2] & g[1]) | (p[3] & p[2] & p[1] & g[0]);
        end
    endfunction

    // carry into member k of a four-wide group
    function cla_c;
        input [3:0] g;
        input [3:0] p;
        input       c;
        input [1:0] k;
        begin
            case (k)
                2'd0:    cla_c = c;
                2'd1:    cla_c = g[0] | (p[0] & c);
                2'd2:    cla_c = g[1] | (p[1] & g[0]) | (p[1] & p[0] & c);
                default: cla_c = g[2] | (p[2] & g[1]) | (p[2] & p[1] & g[0]) | (p[2] & p[1] & p[0] & c);
            endcase
        end
    endfunction

    // sixteen identical slices cascaded
    genvar s, k;
    generate
        for (s = 0; s < NSL; s = s + 1) begin : g_sl
            wire rdn = f_dn[(s+1)*SW];
            wire rup = f_up[s*SW];
            wire qdn = q_dn[(s+1)*SW];
            wire qup = q_up[s*SW];
            bsad_slice #(.W(SW), .N(16)) u_slice (
                .mclk                      (mclk),
                .rst_b                     (rst_b),
                .uins_valid                (uins_valid),
                .source_select_field       (source_select_field),
                .function_select_field     (function_select_field),
                .destination_select_field  (destination_select_field),
                .first_read_address        (first_read_address),
                .second_read_write_address (second_read_write_address),
                .direct_in                 (d_word[s*SW +: SW]),
                .carry_in                  (sc[s]),
                .ram_dn_in                 (rdn),
                .ram_up_in                 (rup),
                .q_dn_in                   (qdn),
                .q_up_in                   (qup),
                .alu_f                     (f_bus[s*SW +: SW]),
                .a_port                    (a_bus[s*SW +: SW]),
                .q_bits                    (q_bus[s*SW +: SW]),
                .grp_gen                   (sg[s]),
                .grp_prop                  (sp[s]),
                .msb_carry                 (smc[s])
            );
        end
    endgenerate
    // three look-ahead levels: groups, super group, final carry
    generate
        for (k = 0; k < NG; k = k + 1) begin : g_grp
            localparam [31:0] KW = k;      // sized copy so a part-select is legal
            assign gg[k] = grp_g(sg[4*k +: 4], sp[4*k +: 4]);
            assign gp[k] = &sp[4*k +: 4];
            assign gc[k] = cla_c(gg, gp, carry_input, KW[1:0]);
            assign sc[4*k]   = gc[k];
            assign sc[4*k+1] = cla_c(sg[4*k +: 4], sp[4*k +: 4], gc[k], 2'd1);
            assign sc[4*k+2] = cla_c(sg[4*k +: 4], sp[4*k +: 4], gc[k], 2'd2);
            assign sc[4*k+3] = cla_c(sg[4*k +: 4], sp[4*k +: 4], gc[k], 2'd3);
        end
    endgenerate
    // control store owns the carry into the bottom slice
    wire cout_all = grp_g(gg, gp) | ((&gp) & carry_input);
    // ****************************************************************
    // output and flags
    // ****************************************************************
    // one dedicated output code shows the first port
    always @(posedge mclk) begin
        if (!rst_b) begin
            y_data_ff        <= {DW{1'b0}};
            y_valid_ff       <= 1'b0;
            zero_flag_ff     <= 1'b0;
            result_sign_ff   <= 1'b0;
            overflow_flag_ff <= 1'b0;
            carry_output_ff  <= 1'b0;
        end else begin
            y_valid_ff <= uins_valid;
            if (uins_valid) begin
                y_data_ff <= (destination_select_field == `BSAD_DST_RAMA) ? a_bus : f_bus;
                zero_flag_ff     <= ~|f_bus;
                result_sign_ff   <= f_bus[DW-1];
                overflow_flag_ff <= smc[NSL-1] ^ cout_all;
                carry_output_ff  <= cout_all;
            end
        end
    end

    // ****************************************************************
    // bus write side
    // ****************************************************************
    // byte-lane merge under strobes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  st;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (st[b]) begin
                    merge[8*b +: 8] = nw[8*b +: 8];
                end
            end
        end
    endfunction

    wire do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;

    // address and data taken in either order, answer after both
    always @(posedge mclk) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BSAD_RESP_OKAY;
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            awaddr_ff     <= {ADDR_W{1'b0}};
            wdata_ff      <= `BSAD_DATA_RST;
            wstrb_ff      <= 4'h0;
            dlo_ff        <= `BSAD_DATA_RST;
            dhi_ff        <= `BSAD_DATA_RST;
            ctrl_ff       <= `BSAD_CTRL_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_ff     <= s_axi_awaddr;
                aw_held_ff    <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_ff     <= s_axi_wdata;
                wstrb_ff     <= s_axi_wstrb;
                w_held_ff    <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held_ff   <= 1'b0;
                w_held_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `BSAD_RESP_OKAY;
                case (awaddr_ff)
                    `BSAD_OFS_DLO:  dlo_ff  <= merge(dlo_ff, wdata_ff, wstrb_ff);
                    `BSAD_OFS_DHI:  dhi_ff  <= merge(dhi_ff, wdata_ff, wstrb_ff);
                    `BSAD_OFS_CTRL: begin
                        if (wstrb_ff[0]) begin
                            ctrl_ff <= wdata_ff[3:0];
                        end
                    end
                    // read-only words accept silently; holes are errors
                    `BSAD_OFS_STATUS, `BSAD_OFS_RES_LO, `BSAD_OFS_RES_HI: ;
                    default: s_axi_bresp <= `BSAD_RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // bus read side
    // ****************************************************************
    // one read at a time; data the cycle after the address
    always @(posedge mclk) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `BSAD_DATA_RST;
            s_axi_rresp   <= `BSAD_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `BSAD_RESP_OKAY;
            case (s_axi_araddr)
                `BSAD_OFS_DLO:    s_axi_rdata <= dlo_ff;
                `BSAD_OFS_DHI:    s_axi_rdata <= dhi_ff;
                `BSAD_OFS_CTRL:   s_axi_rdata <= {28'h000_0000, ctrl_ff};
                `BSAD_OFS_STATUS: s_axi_rdata <= {28'h000_0000, carry_output_ff, overflow_flag_ff,
                                                  result_sign_ff, zero_flag_ff};
                `BSAD_OFS_RES_LO: s_axi_rdata <= y_data_ff[31:0];
                `BSAD_OFS_RES_HI: s_axi_rdata <= y_data_ff[DW-1:DW-32];
                default: begin
                    s_axi_rdata <= `BSAD_DATA_RST;
                    s_axi_rresp <= `BSAD_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // bsad_datapath

// [bsad_ctl_model.sv]
// Purpose: control store model, one microword per go pulse
// Assumes: go and cw change just after a rising edge
// Notes:   fields are held between words
module bsad_ctl_model (
    input  wire        mclk,
    input  wire        go,
    input  wire [17:0] cw,
    output logic       uins_valid,
    output logic [2:0] source_select_field,
    output logic [2:0] function_select_field,
    output logic [2:0] destination_select_field,
    output logic [3:0] first_read_address,
    output logic [3:0] second_read_write_address,
    output logic       carry_input
);
    timeunit 1ns;
    timeprecision 1ns;
    // quiet port until the first word
    initial {uins_valid, source_select_field, function_select_field, destination_select_field,
        first_read_address, second_read_write_address, carry_input} = '0;
    // carry is issued with every word, so no stale carry reaches slice 0
    always @(posedge mclk) begin
        uins_valid <= go;
        if (go) {source_select_field, function_select_field, destination_select_field,
            first_read_address, second_read_write_address, carry_input} <= cw;
    end
endmodule // bsad_ctl_model

// [bsad_chk_sva.sv]
// Purpose: flag and datapath relations at the microword port
// Assumes: one clock, synchronous reset
// Notes:   flags checked against the output only when it carries the alu result
module bsad_chk (
    input wire        mclk,
    input wire        rst_b,
    input wire        uins_valid,
    input wire [2:0]  source_select_field,
    input wire [2:0]  function_select_field,
    input wire [2:0]  destination_select_field,
    input wire [3:0]  first_read_address,
    input wire [3:0]  second_read_write_address,
    input wire        carry_input,
    input wire [63:0] y_data_ff,
    input wire        zero_flag_ff,
    input wire        result_sign_ff,
    input wire        overflow_flag_ff,
    input wire        carry_output_ff
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // helpers: a result-output word, its operand pair, its function, equal addresses
    wire       vld = uins_valid && destination_select_field != 3'h2;
    wire [2:0] ss = source_select_field;
    wire [2:0] fs = function_select_field;
    wire       same = first_read_address == second_read_write_address;
    a_zero_flag: assert property (vld |=> zero_flag_ff == (y_data_ff == 64'h0)) else $error("zero flag");
    a_sign_flag: assert property (vld |=> result_sign_ff == y_data_ff[63]) else $error("sign flag");
    a_zero_sign: assert property (zero_flag_ff |-> !result_sign_ff) else $error("zero with sign");
    a_idle_hold: assert property (!uins_valid |=> $stable(y_data_ff)) else $error("idle output moved");
    a_logic_carry: assert property (uins_valid && fs > 3'h2 |=> !carry_output_ff && !overflow_flag_ff) else $error("lc");
    a_same_addr: assert property (vld && ss == 3'h1 && fs == 3'h6 && same |=> zero_flag_ff) else $error("ports differ");
    a_zero_src: assert property (vld && ss == 3'h7 && fs == 3'h4 |=> y_data_ff == 64'h0) else $error("inhibit");
    a_sub_self: assert property (vld && ss == 3'h1 && fs == 3'h2 && same && carry_input
        |=> zero_flag_ff && carry_output_ff) else $error("self subtract");
endmodule // bsad_chk
bind bsad_datapath bsad_chk u_chk (.*);

// [bsad_datapath_tb_top.sv]
// Purpose: self-checking bench of the 64-bit datapath
// Assumes: control store model feeds the microword port
// Notes:   bus tasks wait for the answer, the watchdog ends a hang
`define CHK(x, e) begin cmp_count++; if ((x) !== (e)) begin n_mismatch++; $display("unexpected %0t %h", $time, x); end end
module bsad_datapath_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 0, rst_b = 0, go = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, uins_valid, carry_input;
    logic [17:0] cw = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, first_read_address, second_read_write_address;
    logic [2:0]  source_select_field, function_select_field, destination_select_field;
    logic [63:0] y_data_ff;
    logic        y_valid_ff, zero_flag_ff, result_sign_ff, overflow_flag_ff, carry_output_ff;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          n_mismatch = 0, cmp_count = 0;
    localparam logic [63:0] R = 64'h5, S = 64'h3;
    logic [63:0] fx [8] = '{R + S + 1, S - R, R - S, R | S, R & S, ~R & S, R ^ S, ~(R ^ S)};
    always #50 mclk = ~mclk;
    bsad_datapath uut (.*);
    bsad_ctl_model u_cs (.*);
    function automatic logic [17:0] u(logic [2:0] s, f, d, logic [3:0] a, b, logic c);
        return {s, f, d, a, b, c};
    endfunction
    // bus write: address and data offered together, each dropped when taken
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
    endtask
    task axr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
        @(posedge mclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        `CHK({s_axi_rresp, s_axi_rdata}, {er, ed})
    endtask
    // one microword, result looked at once it has landed
    task uop(input logic [17:0] w, input logic [63:0] e);
        @(posedge mclk);
        cw <= w;
        go <= 1;
        @(posedge mclk);
        go <= 0;
        @(posedge mclk);
        #1 `CHK(y_data_ff, e)
    endtask
    task give_verdict;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #300000 n_mismatch++;
        give_verdict;
    end
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1;
        axr(8'h08, 2'h0, 32'h0);
        axr(8'h40, 2'h2, 32'h0);
        axw(8'h00, 32'h5);
        axw(8'h04, 32'h0);
        uop(u(7, 0, 3, 0, 1, 0), R);
        axw(8'h00, 32'h3);
        uop(u(7, 0, 3, 0, 2, 0), S);
        for (int f = 0; f < 8; f++) begin
            uop(u(1, f, 1, 1, 2, 1), fx[f]);
            `CHK(result_sign_ff, fx[f][63])
            `CHK({y_valid_ff, carry_output_ff, overflow_flag_ff}, {1'b1, f == 2, 1'b0})
        end
        uop(u(1, 6, 1, 2, 2, 0), 64'h0);
        axr(8'h0C, 2'h0, 32'h1);
        uop(u(1, 2, 1, 1, 1, 1), 64'h0);
        uop(u(7, 4, 1, 0, 0, 0), 64'h0);
        $display("alu tests done");
        uop(u(4, 0, 0, 1, 0, 0), R);
        uop(u(2, 0, 1, 0, 0, 0), R);
        uop(u(4, 0, 7, 1, 3, 0), R);
        uop(u(4, 0, 1, 3, 0, 0), 64'ha);
        axr(8'h10, 2'h0, 32'ha);
        $display("storage tests done");
        give_verdict;
    end
endmodule // bsad_datapath_tb_top
